// file: logic/lpc_pkg.sv
// Purpose : shared constants, types and register map of the low-power clock controller
// Assumes : one 25 MHz reference clock; every slower clock is a one-cycle enable pulse
// Notes   : register offsets are byte addresses of 32-bit words

package lpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NPER   = 8;
  localparam int unsigned DIV_W  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_DEV_CFG    = 8'h00;  // device_config_reg
  localparam logic [7:0] OFS_RUN_GATE   = 8'h04;  // run_gating_reg
  localparam logic [7:0] OFS_SLEEP_GATE = 8'h08;  // sleep_gating_reg
  localparam logic [7:0] OFS_DEEP_GATE  = 8'h0c;  // deep_sleep_gating_reg
  localparam logic [7:0] OFS_RUN_CFG    = 8'h10;  // run_clock_config
  localparam logic [7:0] OFS_SYS_CTRL   = 8'h14;  // core_system_control
  localparam logic [7:0] OFS_DS_CFG     = 8'h18;  // deep_sleep_clock_config
  localparam logic [7:0] OFS_CLP_STAT   = 8'h1c;  // control_lowpower_status
  localparam logic [7:0] OFS_PLL_REQ    = 8'h20;  // control_pll_write_request
  localparam logic [7:0] OFS_PLL_RECL   = 8'h24;  // master_pll_write_reclaim
  localparam logic [7:0] OFS_PLL_CTL    = 8'h28;  // main_pll_control
  localparam logic [7:0] OFS_PLL_MULT   = 8'h2c;  // main_pll_multiplier
  localparam logic [7:0] OFS_PLL_STAT   = 8'h30;  // main_pll_status_reg
  localparam logic [7:0] OFS_SYS_DIV    = 8'h34;  // system_divider_select
  localparam logic [7:0] OFS_CPG        = 8'h38;  // control_peripheral_gating
  localparam logic [7:0] OFS_CAN_CFG    = 8'h3c;  // can clock source config
  localparam logic [7:0] OFS_MODE_STAT  = 8'h40;  // mode and ownership status

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned RUN_CFG_ACG   = 0;   // auto_gating_select
  localparam int unsigned RUN_CFG_DIV   = 4;   // master_subsystem_divider [7:4]
  localparam int unsigned SYS_CTRL_DS   = 0;   // deep_sleep_select
  localparam int unsigned SYS_CTRL_SOE  = 1;   // sleep_on_exit
  localparam int unsigned DS_CFG_SRC    = 0;   // deep_sleep_source_select [1:0]
  localparam int unsigned DS_CFG_DIV    = 4;   // deep_sleep_divider_override [7:4]
  localparam int unsigned CPG_LPM       = 0;   // low-power mode select [1:0]
  localparam int unsigned CPG_GATE      = 8;   // peripheral gates [15:8]
  localparam int unsigned CPG_T2SRC     = 16;  // timer 2 source [17:16]
  localparam int unsigned CAN0_SRC      = 0;   // [1:0]
  localparam int unsigned CAN1_SRC      = 2;   // [3:2]
  localparam int unsigned OWN_BIT       = 0;   // request / reclaim bit

  ////////////////////////////////////////////////////////////////////////////
  // encodings
  localparam logic [1:0] DS_SRC_SLOW  = 2'h0;
  localparam logic [1:0] DS_SRC_FAST  = 2'h1;
  localparam logic [1:0] DS_SRC_OSC   = 2'h2;
  localparam logic [1:0] CAN_SRC_MS   = 2'h0;
  localparam logic [1:0] CAN_SRC_OSC  = 2'h1;
  localparam logic [1:0] CAN_SRC_AUX  = 2'h2;
  localparam logic [1:0] T2_SRC_SYS   = 2'h0;
  localparam logic [1:0] T2_SRC_OSC   = 2'h1;
  localparam logic [1:0] T2_SRC_FAST  = 2'h2;
  localparam logic [1:0] LPM_STANDBY  = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {M_RUN, M_SLEEP, M_DEEP, M_ISR} lpc_mstate_t;
  typedef enum logic [1:0] {C_NORMAL, C_IDLE, C_STANDBY} lpc_cstate_t;

  // source clocks, each a one-cycle enable pulse
  typedef struct packed {
    logic pll;
    logic osc;
    logic aux;
    logic slow;
    logic fast;
  } lpc_src_t;

  // gated clock enables and clock on/off levels
  typedef struct packed {
    logic            m_cpu_en;
    logic            m_sys_en;
    logic [NPER-1:0] m_periph_en;
    logic [1:0]      can_en;
    logic            wdog_en;
    logic            main_pll_on;
    logic            usb_pll_on;
    logic            analog_on;
    logic            osc_on;
    logic            c_in_en;
    logic            c_cpu_en;
    logic            c_sys_en;
    logic [NPER-1:0] c_periph_en;
    logic            t2_en;
  } lpc_gate_t;

  typedef struct packed {
    logic [NPER-1:0]  dev_cfg;
    logic [NPER-1:0]  run_gate;
    logic [NPER-1:0]  sleep_gate;
    logic [NPER-1:0]  deep_gate;
    logic             auto_gating_select;
    logic [DIV_W-1:0] ms_div;
    logic             deep_sel;
    logic             soe;
    logic [1:0]       ds_src;
    logic [DIV_W-1:0] ds_div;
    logic [7:0]       clp_stat;
    logic             pll_owner;  // 0 master, 1 control
    logic [7:0]       pll_ctl;
    logic [7:0]       pll_mult;
    logic [7:0]       sys_div;
    logic [1:0]       cpg_lpm;
    logic [NPER-1:0]  cpg_gate;
    logic [1:0]       t2_src;
    logic [1:0]       can0_src;
    logic [1:0]       can1_src;
  } lpc_regs_t;

  typedef struct packed {
    lpc_mstate_t       mstate;
    logic              lp_deep;
    lpc_cstate_t       cstate;
    lpc_regs_t         regs;
    lpc_gate_t         gate;
    logic [DATA_W-1:0] rdata;
  } lpc_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             pulse;
  } lpc_div_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam lpc_regs_t REGS_RST = '{dev_cfg: 8'hff, run_gate: 8'hff, sleep_gate: 8'h00,
                                     deep_gate: 8'h00, ms_div: 4'h0, ds_src: DS_SRC_SLOW,
                                     ds_div: 4'h0, pll_mult: 8'h01, cpg_gate: 8'hff,
                                     default: '0};
  localparam lpc_gate_t GATE_RST = '{main_pll_on: 1'b1, usb_pll_on: 1'b1, analog_on: 1'b1,
                                     osc_on: 1'b1, default: '0};
  localparam lpc_state_t STATE_RST = '{mstate: M_RUN, lp_deep: 1'b0, cstate: C_NORMAL,
                                       regs: REGS_RST, gate: GATE_RST, rdata: '0};
  localparam lpc_div_state_t DIV_RST = '{cnt: 4'h0, pulse: 1'b0};

endpackage : lpc_pkg

// file: logic/lpc_clk_div.sv
// Purpose : divides a stream of enable pulses by div_i + 1
// Assumes : en_i is a one-cycle pulse on ref_clk_i
// Notes   : output pulse lags the dividing input pulse by one cycle
`timescale 1ns/1ns

module lpc_clk_div
(
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     en_i,
  input  wire logic [lpc_pkg::DIV_W-1:0] div_i,
  output logic                          pulse_o
);

  lpc_pkg::lpc_div_state_t st_q;
  lpc_pkg::lpc_div_state_t st_d;

  // count input pulses, emit one every div_i + 1
  always_comb
  begin
    st_d       = st_q;
    st_d.pulse = 1'b0;
    if (en_i)
    begin
      if (st_q.cnt >= div_i)
      begin
        st_d.cnt   = '0;
        st_d.pulse = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      st_q <= lpc_pkg::DIV_RST;
    else
      st_q <= st_d;
  end

  assign pulse_o = st_q.pulse;

endmodule : lpc_clk_div

// file: logic/lpc_clock_ctrl.sv
// Purpose : low-power clock control for master and control subsystems
// Assumes : source clocks arrive as one-cycle enable pulses synchronous to ref_clk_i
// Notes   : gated clocks leave as enable pulses; on/off levels for plls and oscillator
//
// Summary of operation
// - run mode clocks from divided pll clock
// - can clock source selectable; watchdog uses oscillator
// - master peripheral gating applies only to configured-enabled peripherals
// - wfi stops cpu; deep or plain sleep
// - configured interrupt returns to run mode
// - sleep stops master cpu clock only; system clock keeps running
// - sleep gating: run or sleep register
// - sleep keeps run-mode peripheral frequency
// - sleep-on-exit returns to low-power after isr
// - deep sleep stops plls, analog, control input
// - deep sleep gating: run or deep register
// - deep sleep source: slow, fast or oscillator
// - deep source divided by override, then master divider
// - internal deep source turns oscillator off
// - pll registers owned by master, transferable
// - control peripheral clocks individually gated
// - control cpu and system clocks generated
// - timer 2 may use oscillator or fast clock
// - control modes normal, idle, standby
// - idle stops control cpu clock only
// - standby stops input, cpu, system clocks
`timescale 1ns/1ns

module lpc_clock_ctrl
(
  input  wire logic                           ref_clk_i,
  input  wire logic                           reset_i,
  input  wire logic [lpc_pkg::ADDR_W-1:0]     addr_i,
  input  wire logic [lpc_pkg::DATA_W-1:0]     wdata_i,
  input  wire logic                           we_i,
  input  wire logic                           re_i,
  input  wire logic                           bus_ctl_i,
  output logic      [lpc_pkg::DATA_W-1:0]     rdata_o,
  input  wire lpc_pkg::lpc_src_t              src_i,
  input  wire logic                           wfi_i,
  input  wire logic                           wake_i,
  input  wire logic                           isr_done_i,
  input  wire logic                           ctl_idle_i,
  input  wire logic                           ctl_wake_i,
  output lpc_pkg::lpc_gate_t                  clk_o,
  output lpc_pkg::lpc_mstate_t                mstate_o,
  output lpc_pkg::lpc_cstate_t                cstate_o
);

  lpc_pkg::lpc_state_t st_q;
  lpc_pkg::lpc_state_t st_d;
  logic                ds_src_pulse;
  logic                ds_pulse;
  logic                ms_in;
  logic                ms_pulse;
  logic                in_deep;
  logic                low_power;
  logic                write_ok;
  logic [7:0]          dev_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // deep sleep source and divider chain
  assign in_deep   = (st_q.mstate == lpc_pkg::M_DEEP);
  assign low_power = (st_q.mstate == lpc_pkg::M_SLEEP) || in_deep;
  assign dev_cfg   = st_q.regs.dev_cfg;

  // pick the deep sleep source pulse
  always_comb
  begin
    case (st_q.regs.ds_src)
      lpc_pkg::DS_SRC_SLOW: ds_src_pulse = src_i.slow;
      lpc_pkg::DS_SRC_FAST: ds_src_pulse = src_i.fast;
      lpc_pkg::DS_SRC_OSC:  ds_src_pulse = src_i.osc;
      default:              ds_src_pulse = 1'b0;
    endcase
  end

  // first stage: deep sleep divider override
  lpc_clk_div u_ds_div
  (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .en_i      (ds_src_pulse),
    .div_i     (st_q.regs.ds_div),
    .pulse_o   (ds_pulse)
  );

  // second stage: master subsystem divider, fed by pll in run and deep chain in deep sleep
  assign ms_in = in_deep ? ds_pulse : src_i.pll;

  lpc_clk_div u_ms_div
  (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .en_i      (ms_in),
    .div_i     (st_q.regs.ms_div),
    .pulse_o   (ms_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  assign write_ok = (st_q.regs.pll_owner == bus_ctl_i);

  always_comb
  begin
    st_d = st_q;

    // master subsystem mode sequence
    case (st_q.mstate)
      lpc_pkg::M_RUN:
      begin
        if (wfi_i)
        begin
          st_d.lp_deep = st_q.regs.deep_sel;
          st_d.mstate  = st_q.regs.deep_sel ? lpc_pkg::M_DEEP : lpc_pkg::M_SLEEP;
        end
      end
      lpc_pkg::M_SLEEP,
      lpc_pkg::M_DEEP:
      begin
        if (wake_i)
          st_d.mstate = st_q.regs.soe ? lpc_pkg::M_ISR : lpc_pkg::M_RUN;
      end
      lpc_pkg::M_ISR:
      begin
        if (isr_done_i)
        begin
          if (st_q.regs.soe)
            st_d.mstate = st_q.lp_deep ? lpc_pkg::M_DEEP : lpc_pkg::M_SLEEP;
          else
            st_d.mstate = lpc_pkg::M_RUN;
        end
      end
      default: st_d.mstate = lpc_pkg::M_RUN;
    endcase

    // control subsystem mode sequence
    case (st_q.cstate)
      lpc_pkg::C_NORMAL:
      begin
        if (ctl_idle_i)
          st_d.cstate = (st_q.regs.cpg_lpm == lpc_pkg::LPM_STANDBY) ? lpc_pkg::C_STANDBY
                                                                    : lpc_pkg::C_IDLE;
      end
      lpc_pkg::C_IDLE:
      begin
        if (ctl_wake_i)
          st_d.cstate = lpc_pkg::C_NORMAL;
      end
      lpc_pkg::C_STANDBY:
      begin
        // no input clock reaches the control side while the master is in deep sleep
        if (ctl_wake_i && !in_deep)
          st_d.cstate = lpc_pkg::C_NORMAL;
      end
      default: st_d.cstate = lpc_pkg::C_NORMAL;
    endcase

    // register writes
    if (we_i)
    begin
      case (addr_i)
        lpc_pkg::OFS_DEV_CFG:    st_d.regs.dev_cfg    = wdata_i[7:0];
        lpc_pkg::OFS_RUN_GATE:   st_d.regs.run_gate   = wdata_i[7:0];
        lpc_pkg::OFS_SLEEP_GATE: st_d.regs.sleep_gate = wdata_i[7:0];
        lpc_pkg::OFS_DEEP_GATE:  st_d.regs.deep_gate  = wdata_i[7:0];
        lpc_pkg::OFS_RUN_CFG:
        begin
          st_d.regs.auto_gating_select    = wdata_i[lpc_pkg::RUN_CFG_ACG];
          st_d.regs.ms_div = wdata_i[lpc_pkg::RUN_CFG_DIV +: 4];
        end
        lpc_pkg::OFS_SYS_CTRL:
        begin
          st_d.regs.deep_sel = wdata_i[lpc_pkg::SYS_CTRL_DS];
          st_d.regs.soe      = wdata_i[lpc_pkg::SYS_CTRL_SOE];
        end
        lpc_pkg::OFS_DS_CFG:
        begin
          st_d.regs.ds_src = wdata_i[lpc_pkg::DS_CFG_SRC +: 2];
          st_d.regs.ds_div = wdata_i[lpc_pkg::DS_CFG_DIV +: 4];
        end
        lpc_pkg::OFS_CLP_STAT: st_d.regs.clp_stat = wdata_i[7:0];
        lpc_pkg::OFS_PLL_REQ:
        begin
          if (bus_ctl_i && wdata_i[lpc_pkg::OWN_BIT])
            st_d.regs.pll_owner = 1'b1;
        end
        lpc_pkg::OFS_PLL_RECL:
        begin
          if (!bus_ctl_i && wdata_i[lpc_pkg::OWN_BIT])
            st_d.regs.pll_owner = 1'b0;
        end
        lpc_pkg::OFS_PLL_CTL:  if (write_ok) st_d.regs.pll_ctl  = wdata_i[7:0];
        lpc_pkg::OFS_PLL_MULT: if (write_ok) st_d.regs.pll_mult = wdata_i[7:0];
        lpc_pkg::OFS_SYS_DIV:  if (write_ok) st_d.regs.sys_div  = wdata_i[7:0];
        lpc_pkg::OFS_CPG:
        begin
          st_d.regs.cpg_lpm  = wdata_i[lpc_pkg::CPG_LPM +: 2];
          st_d.regs.cpg_gate = wdata_i[lpc_pkg::CPG_GATE +: 8];
          st_d.regs.t2_src   = wdata_i[lpc_pkg::CPG_T2SRC +: 2];
        end
        lpc_pkg::OFS_CAN_CFG:
        begin
          st_d.regs.can0_src = wdata_i[lpc_pkg::CAN0_SRC +: 2];
          st_d.regs.can1_src = wdata_i[lpc_pkg::CAN1_SRC +: 2];
        end
        default: ;
      endcase
    end

    // read data stands only in the cycle after the strobe
    st_d.rdata = '0;
    if (re_i)
    begin
      case (addr_i)
        lpc_pkg::OFS_DEV_CFG:    st_d.rdata = {24'h0, st_q.regs.dev_cfg};
        lpc_pkg::OFS_RUN_GATE:   st_d.rdata = {24'h0, st_q.regs.run_gate};
        lpc_pkg::OFS_SLEEP_GATE: st_d.rdata = {24'h0, st_q.regs.sleep_gate};
        lpc_pkg::OFS_DEEP_GATE:  st_d.rdata = {24'h0, st_q.regs.deep_gate};
        lpc_pkg::OFS_RUN_CFG:    st_d.rdata = {24'h0, st_q.regs.ms_div, 3'h0, st_q.regs.auto_gating_select};
        lpc_pkg::OFS_SYS_CTRL:   st_d.rdata = {30'h0, st_q.regs.soe, st_q.regs.deep_sel};
        lpc_pkg::OFS_DS_CFG:     st_d.rdata = {24'h0, st_q.regs.ds_div, 2'h0, st_q.regs.ds_src};
        lpc_pkg::OFS_CLP_STAT:   st_d.rdata = {24'h0, st_q.regs.clp_stat};
        lpc_pkg::OFS_PLL_REQ:    st_d.rdata = {31'h0, st_q.regs.pll_owner};
        lpc_pkg::OFS_PLL_RECL:   st_d.rdata = {31'h0, !st_q.regs.pll_owner};
        lpc_pkg::OFS_PLL_CTL:    st_d.rdata = {24'h0, st_q.regs.pll_ctl};
        lpc_pkg::OFS_PLL_MULT:   st_d.rdata = {24'h0, st_q.regs.pll_mult};
        lpc_pkg::OFS_PLL_STAT:   st_d.rdata = {31'h0, st_q.gate.main_pll_on};
        lpc_pkg::OFS_SYS_DIV:    st_d.rdata = {24'h0, st_q.regs.sys_div};
        lpc_pkg::OFS_CPG:        st_d.rdata = {14'h0, st_q.regs.t2_src, st_q.regs.cpg_gate,
                                               6'h0, st_q.regs.cpg_lpm};
        lpc_pkg::OFS_CAN_CFG:    st_d.rdata = {28'h0, st_q.regs.can1_src, st_q.regs.can0_src};
        lpc_pkg::OFS_MODE_STAT:  st_d.rdata = {27'h0, st_q.cstate, st_q.mstate, st_q.regs.pll_owner};
        default:                 st_d.rdata = '0;
      endcase
    end

    // master side clock enables
    st_d.gate.m_sys_en = ms_pulse;
    st_d.gate.m_cpu_en = ms_pulse && !low_power;
    if ((st_q.mstate == lpc_pkg::M_SLEEP) && st_q.regs.auto_gating_select)
      st_d.gate.m_periph_en = st_q.regs.sleep_gate & dev_cfg & {8{ms_pulse}};
    else if (in_deep && st_q.regs.auto_gating_select)
      st_d.gate.m_periph_en = st_q.regs.deep_gate & dev_cfg & {8{ms_pulse}};
    else
      st_d.gate.m_periph_en = st_q.regs.run_gate & dev_cfg & {8{ms_pulse}};

    // plls and analog stop in deep sleep; oscillator and watchdog too, unless the oscillator is the deep source
    st_d.gate.main_pll_on = !in_deep;
    st_d.gate.usb_pll_on  = !in_deep;
    st_d.gate.analog_on   = !in_deep;
    st_d.gate.osc_on      = !(in_deep && (st_q.regs.ds_src != lpc_pkg::DS_SRC_OSC));
    st_d.gate.wdog_en     = src_i.osc && st_d.gate.osc_on;

    // can clock sources
    case (st_q.regs.can0_src)
      lpc_pkg::CAN_SRC_MS:  st_d.gate.can_en[0] = ms_pulse;
      lpc_pkg::CAN_SRC_OSC: st_d.gate.can_en[0] = src_i.osc;
      lpc_pkg::CAN_SRC_AUX: st_d.gate.can_en[0] = src_i.aux;
      default:              st_d.gate.can_en[0] = 1'b0;
    endcase
    case (st_q.regs.can1_src)
      lpc_pkg::CAN_SRC_MS:  st_d.gate.can_en[1] = ms_pulse;
      lpc_pkg::CAN_SRC_OSC: st_d.gate.can_en[1] = src_i.osc;
      lpc_pkg::CAN_SRC_AUX: st_d.gate.can_en[1] = src_i.aux;
      default:              st_d.gate.can_en[1] = 1'b0;
    endcase

    // control side clocks
    st_d.gate.c_in_en     = src_i.pll && !in_deep && (st_q.cstate != lpc_pkg::C_STANDBY);
    st_d.gate.c_cpu_en    = st_d.gate.c_in_en && (st_q.cstate == lpc_pkg::C_NORMAL);
    st_d.gate.c_sys_en    = st_d.gate.c_in_en;
    st_d.gate.c_periph_en = st_q.regs.cpg_gate & {8{st_d.gate.c_sys_en}};
    case (st_q.regs.t2_src)
      lpc_pkg::T2_SRC_SYS:  st_d.gate.t2_en = st_d.gate.c_sys_en;
      lpc_pkg::T2_SRC_OSC:  st_d.gate.t2_en = src_i.osc && st_d.gate.osc_on;
      lpc_pkg::T2_SRC_FAST: st_d.gate.t2_en = src_i.fast;
      default:              st_d.gate.t2_en = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      st_q <= lpc_pkg::STATE_RST;
    else
      st_q <= st_d;
  end

  // outputs straight from the state register
  assign rdata_o  = st_q.rdata;
  assign clk_o    = st_q.gate;
  assign mstate_o = st_q.mstate;
  assign cstate_o = st_q.cstate;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_wfi_enters_lp: assert property ((st_q.mstate == lpc_pkg::M_RUN) && wfi_i
    |=> (st_q.mstate == ($past(st_q.regs.deep_sel) ? lpc_pkg::M_DEEP : lpc_pkg::M_SLEEP)))
    else $error("wfi did not enter the selected low-power mode");

  a_wake_to_run: assert property (low_power && wake_i && !st_q.regs.soe
    |=> (st_q.mstate == lpc_pkg::M_RUN))
    else $error("wake did not return to run");

  a_sleep_cpu_off: assert property ((st_q.mstate == lpc_pkg::M_SLEEP)
    |=> !clk_o.m_cpu_en)
    else $error("cpu clock ran in sleep");

  a_sleep_gate_sel: assert property ((st_q.mstate == lpc_pkg::M_SLEEP) && st_q.regs.auto_gating_select && ms_pulse
    |=> (clk_o.m_periph_en == ($past(st_q.regs.sleep_gate) & $past(dev_cfg))))
    else $error("sleep gating register not applied");

  a_gate_enabled: assert property (1'b1
    |=> ((clk_o.m_periph_en & ~$past(dev_cfg)) == 8'h00))
    else $error("clock reached a peripheral that is not enabled");

  a_soe_isr_back: assert property (low_power && wake_i && st_q.regs.soe
    |=> (st_q.mstate == lpc_pkg::M_ISR))
    else $error("sleep-on-exit wake did not enter isr");

  a_isr_to_lp: assert property ((st_q.mstate == lpc_pkg::M_ISR) && isr_done_i && st_q.regs.soe
    |=> (st_q.mstate == ($past(st_q.lp_deep) ? lpc_pkg::M_DEEP : lpc_pkg::M_SLEEP)))
    else $error("isr end did not return to the saved low-power mode");

  a_deep_clks_off: assert property (in_deep
    |=> !clk_o.main_pll_on && !clk_o.usb_pll_on && !clk_o.analog_on && !clk_o.c_in_en)
    else $error("clock left running in deep sleep");

  a_osc_off_deep: assert property (in_deep && (st_q.regs.ds_src != lpc_pkg::DS_SRC_OSC)
    |=> !clk_o.osc_on && !clk_o.wdog_en)
    else $error("oscillator on with internal deep sleep source");

  a_pll_owner_wr: assert property (we_i && (addr_i == lpc_pkg::OFS_PLL_MULT) && !write_ok
    |=> $stable(st_q.regs.pll_mult))
    else $error("non-owner wrote a pll register");

  a_idle_cpu_off: assert property ((st_q.cstate == lpc_pkg::C_IDLE) && src_i.pll && !in_deep
    |=> !clk_o.c_cpu_en && clk_o.c_sys_en)
    else $error("idle clocks wrong");

  a_standby_off: assert property ((st_q.cstate == lpc_pkg::C_STANDBY)
    |=> !clk_o.c_in_en && !clk_o.c_cpu_en && !clk_o.c_sys_en && (clk_o.c_periph_en == 8'h00))
    else $error("clock running in standby");

endmodule : lpc_clock_ctrl

// file: testbench/lpc_src_model.sv
// Purpose: source clock pulses as seen by the controller
// Assumes: ref_clk_i at 25 MHz
// Notes  : rates are scaled down so each source is distinct
`timescale 1ns/1ns
module lpc_src_model
(
  input  wire logic         ref_clk_i,
  output lpc_pkg::lpc_src_t src_o
);
  logic [3:0] cnt_q = 4'h0;
  // free count sets the pulse rate of every source but pll, which is always on
  always_ff @(posedge ref_clk_i)
    cnt_q <= cnt_q + 4'h1;
  assign src_o = '{pll: 1'b1, osc: cnt_q[0], aux: &cnt_q[1:0], slow: &cnt_q[2:0], fast: cnt_q == 4'h5};
endmodule : lpc_src_model

// file: testbench/lpc_clock_ctrl_tb.sv
// Purpose: self-checking bench of lpc_clock_ctrl
// Assumes: 25 MHz clock, synchronous reset held 10 cycles
// Notes  : random gating values from an lfsr started at 7
`timescale 1ns/1ns
module lpc_clock_ctrl_tb;
  logic        ref_clk_i = 1'b0, reset_i = 1'b1, we_i = 1'b0, re_i = 1'b0, ctl = 1'b0, cpu;
  logic [7:0]  addr_i = 8'h00, rnd = 8'h07, dcfg, sgate, acc, oth;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [4:0]  evt = 5'h0;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, nsys = 0;
  lpc_pkg::lpc_src_t    src;
  lpc_pkg::lpc_gate_t   clk;
  lpc_pkg::lpc_mstate_t ms;
  lpc_pkg::lpc_cstate_t cs;
  lpc_src_model i_src (.ref_clk_i(ref_clk_i), .src_o(src));
  lpc_clock_ctrl i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .bus_ctl_i(ctl), .rdata_o(rdata_o), .src_i(src), .wfi_i(evt[0]), .wake_i(evt[1]),
    .isr_done_i(evt[2]), .ctl_idle_i(evt[3]), .ctl_wake_i(evt[4]), .clk_o(clk), .mstate_o(ms), .cstate_o(cs));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  // cycle ceiling against hangs
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    ctl <= c;
    we_i <= 1'b1;
    @(posedge ref_clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge ref_clk_i);
    re_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd
  // one-cycle event pulse, then let mode and clock outputs settle
  task automatic pulse(input logic [4:0] m);
    @(posedge ref_clk_i);
    evt <= m;
    @(posedge ref_clk_i);
    evt <= 5'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : pulse
  // gather which peripheral and cpu enables pulsed over n cycles
  task automatic gather(input int n);
    acc = 8'h0;
    cpu = 1'b0;
    oth = 8'h0;
    nsys = 0;
    repeat (n)
    begin
      @(posedge ref_clk_i);
      #1 acc = acc | clk.m_periph_en;
      cpu = cpu | clk.m_cpu_en;
      oth = oth | {clk.can_en, clk.wdog_en, clk.c_cpu_en, clk.c_sys_en, clk.t2_en, clk.osc_on, |clk.c_periph_en};
      nsys = nsys + clk.m_sys_en;
    end
  endtask : gather
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd(8'h00, 32'hff);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'hfc, 32'h0);
    wr(8'h28, 32'h5a, 1'b1);
    rd(8'h28, 32'h0);
    wr(8'h20, 32'h1, 1'b1);
    wr(8'h28, 32'h5a, 1'b1);
    rd(8'h28, 32'h5a);
    wr(8'h24, 32'h1, 1'b0);
    rd(8'h40, 32'h0);
    rnd = lfsr(rnd);
    dcfg = rnd;
    rnd = lfsr(rnd);
    sgate = rnd;
    wr(8'h00, {24'h0, dcfg}, 1'b0);
    wr(8'h08, {24'h0, sgate}, 1'b0);
    wr(8'h10, 32'h1, 1'b0);
    pulse(5'h01);
    chk(ms, 32'h1);
    gather(12);
    chk({cpu, acc}, {1'b0, dcfg & sgate});
    chk(nsys, 32'hc);
    chk(oth, 32'hff);
    wr(8'h14, 32'h2, 1'b0);
    pulse(5'h02);
    chk(ms, 32'h3);
    pulse(5'h04);
    chk(ms, 32'h1);
    wr(8'h14, 32'h0, 1'b0);
    pulse(5'h02);
    chk(ms, 32'h0);
    wr(8'h1c, 32'h1, 1'b1);
    wr(8'h38, 32'hff01, 1'b1);
    pulse(5'h08);
    chk(cs, 32'h2);
    rd(8'h1c, 32'h1);
    wr(8'h14, 32'h1, 1'b0);
    wr(8'h10, 32'h0, 1'b0);
    pulse(5'h01);
    chk({ms, clk.main_pll_on, clk.usb_pll_on, clk.analog_on, clk.osc_on}, 32'h20);
    gather(40);
    chk({cpu, acc}, {1'b0, dcfg});
    chk(nsys, 32'h5);
    chk(oth, 32'hc0);
    pulse(5'h02);
    chk({ms, clk.main_pll_on}, 32'h1);
    pulse(5'h10);
    chk(cs, 32'h0);
    wr(8'h38, 32'h2ff00, 1'b1);
    pulse(5'h08);
    chk(cs, 32'h1);
    wr(8'h3c, 32'h9, 1'b0);
    wr(8'h10, 32'h30, 1'b0);
    gather(40);
    chk({cpu, acc}, {1'b1, dcfg});
    chk(nsys, 32'ha);
    chk(oth, 32'hef);
    pulse(5'h10);
    wr(8'h38, 32'h2ff01, 1'b1);
    pulse(5'h08);
    rd(8'h40, 32'h10);
    wr(8'h18, 32'h12, 1'b0);
    pulse(5'h01);
    gather(20);
    gather(64);
    chk({ms, cpu, acc}, {2'h2, 1'b0, dcfg});
    chk(nsys, 32'h4);
    chk(oth, 32'he6);
    conclude();
  end
endmodule : lpc_clock_ctrl_tb
